// file: hw/lcd_cmd_pkg.sv
// Constants and types shared by the LCD driver command decoder
package lcd_cmd_pkg;

  // Bus slave address, upper six bits fixed, low bit from the strap pin
  localparam logic [5:0] SLAVE_ADDR_HI     = 6'h1c;

  // Drive mode codes
  localparam logic [1:0] MODE_STATIC       = 2'h1;
  localparam logic [1:0] MODE_MUX2         = 2'h2;
  localparam logic [1:0] MODE_MUX3         = 2'h3;
  localparam logic [1:0] MODE_MUX4         = 2'h0;

  // Blink rate codes
  localparam logic [1:0] BLINK_OFF         = 2'h0;
  localparam logic [1:0] BLINK_2HZ         = 2'h1;
  localparam logic [1:0] BLINK_1HZ         = 2'h2;
  localparam logic [1:0] BLINK_HALF_HZ     = 2'h3;

  // Opcode patterns below the continuation flag
  localparam int         CONT_BIT          = 7;
  localparam logic [1:0] OPC_MODE_SET      = 2'h2;   // bits 6:5
  localparam logic [3:0] OPC_DEV_SELECT    = 4'hc;   // bits 6:3
  localparam logic [4:0] OPC_BANK_SELECT   = 5'h1e;  // bits 6:2
  localparam logic [3:0] OPC_BLINK         = 4'he;   // bits 6:3

  // Mode set, bank select and blink field positions
  localparam int         POS_POWER_SAVE    = 4;
  localparam int         POS_DISPLAY_EN    = 3;
  localparam int         POS_BIAS          = 2;
  localparam int         POS_BANK_IN       = 1;
  localparam int         POS_BANK_OUT      = 0;
  localparam int         POS_BLINK_ALT     = 2;

  // Display RAM addressing
  localparam logic [6:0] RAM_ADDR_LAST     = 7'h27;  // 39
  localparam logic [5:0] FILL_STEP_STATIC  = 6'h08;
  localparam logic [5:0] FILL_STEP_MUX2    = 6'h04;
  localparam logic [5:0] FILL_STEP_MUX3    = 6'h03;
  localparam logic [5:0] FILL_STEP_MUX4    = 6'h02;

  // Values after reset
  localparam logic [1:0] RST_DRIVE_MODE    = MODE_MUX4;
  localparam logic       RST_BIAS          = 1'b0;
  localparam logic       RST_DISPLAY_EN    = 1'b0;
  localparam logic       RST_POWER_SAVE    = 1'b0;
  localparam logic [5:0] RST_RAM_POINTER   = 6'h00;
  localparam logic [2:0] RST_SUBADDR       = 3'h0;
  localparam logic [1:0] RST_BLINK_RATE    = BLINK_OFF;

  // Backplane phase length in display clock cycles
  localparam logic [3:0] BP_PHASE_CYCLES   = 4'h4;

  typedef enum logic [2:0] {
    XF_IDLE,
    XF_ADDR,
    XF_CMD,
    XF_DATA,
    XF_SKIP
  } xfer_state_t;

endpackage

// file: hw/lcd_driver_command_decoder.sv
// Command decoder, display controller status and cascade sync for a segment LCD driver
// What this block does
// [R1] Mode set: continuation in bit 7, bits 6:5 are 10, then power-save, enable, bias, mode.
// [R2] Drive mode bits: 01 static, 10 1:2, 11 1:3, 00 1:4 multiplex.
// [R3] Bias bit 0 gives one-third bias, 1 gives one-half bias.
// [R4] Display enable bit 0 blanks the display, 1 enables it.
// [R5] Power-save bit 0 is normal operation, 1 is reduced dissipation.
// [R6] Bit 6 clear loads six low bits into the RAM pointer, range 0 to 39.
// [R7] Bits 6:3 equal 1100 load three low bits into the subaddress counter.
// [R8] Bank select bit 1 chooses the input bank for arriving data.
// [R9] Bank select bit 0 chooses the output bank read to the display.
// [R10] Bank select is ignored in 1:3 and 1:4 multiplex modes.
// [R11] Blink: bits 6:3 equal 1110, bit 2 blink mode, bits 1:0 rate.
// [R12] Blink rate: 00 off, 01 2 Hz, 10 1 Hz, 11 0.5 Hz.
// [R13] Blink mode 1 alternates RAM banks, but not in 1:3 or 1:4 modes.
// [R14] Execute decoded commands, update status, write data in filling order.
// [R15] Up to sixteen devices: 3-bit subaddress plus slave address low bit.
// [R16] Sync line is bidirectional, driven only open-drain, pulled up otherwise.
// [R17] Assert sync at onset of the last active backplane phase, else monitor it.
// [R18] On lost alignment, resynchronise to the first device asserting sync.
// [R19] Devices come up aligned after reset with no bus command.
// [R20] Continuation set means another command; clear means following bytes are data.
// [R21] Answer slave address 0111000 or 0111001 per strap; ignore other transfers.
// [R22] Store data at pointer and subaddress, advance both; ack only on subaddress match.
// [R23] Unknown command opcodes change nothing but are still acknowledged.
`timescale 1ns/1ps
`default_nettype none

module lcd_driver_command_decoder (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  // Byte stream from the bus receiver, same clock
  input  wire logic                       rx_start_i,
  input  wire logic                       rx_stop_i,
  input  wire logic                       rx_valid_i,
  input  wire logic [7:0]                 rx_byte_i,
  output logic                            ack_valid_o,
  output logic                            ack_o,
  // Straps from pins
  input  wire logic                       slave_addr_low_pin_i,
  input  wire logic [2:0]                 hw_subaddr_i,
  // Status
  output logic [1:0]                      drive_mode_o,
  output logic                            bias_half_o,
  output logic                            display_en_o,
  output logic                            power_save_bit_o,
  output logic [5:0]                      ram_pointer_field_o,
  output logic [2:0]                      subaddr_counter_o,
  output logic                            bank_in_o,
  output logic                            bank_out_o,
  output logic [1:0]                      blink_rate_o,
  output logic                            blink_alt_o,
  // Display RAM write port
  output logic                            ram_wr_o,
  output logic [5:0]                      ram_wr_addr_o,
  output logic                            ram_wr_bank_o,
  output logic [7:0]                      ram_wr_data_o,
  // Link (display clock) side, plus the spare status field registered on the bus clock
  input  wire logic                       disp_clk_i,
  input  wire logic                       sync_n_i,
  output logic                            sync_n_o,
  output logic                            sync_oe_o,
  output logic [lcd_cmd_pkg::MODE_MUX2:0] unused_dummy_o,
  output logic [3:0]                      backplane_output_o
);
  import lcd_cmd_pkg::*;

  // Strap synchronisers
  logic [2:0]  sub_s1_reg;
  logic [2:0]  sub_s2_reg;
  logic        sa0_s1_reg;
  logic        sa0_s2_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sub_s1_reg <= 3'h0;
      sub_s2_reg <= 3'h0;
      sa0_s1_reg <= 1'b0;
      sa0_s2_reg <= 1'b0;
    end else begin
      sub_s1_reg <= hw_subaddr_i;
      sub_s2_reg <= sub_s1_reg;
      sa0_s1_reg <= slave_addr_low_pin_i;
      sa0_s2_reg <= sa0_s1_reg;
    end
  end

  // Byte classification
  xfer_state_t state_reg;
  logic        addr_match;
  logic        is_cont;
  logic        is_mode_set;
  logic        is_ptr_load;
  logic        is_dev_sel;
  logic        is_bank_sel;
  logic        is_blink;
  logic        mux_low;
  logic        sub_match;
  logic        cmd_byte;
  logic        data_byte;

  assign addr_match  = (rx_byte_i[7:1] == {SLAVE_ADDR_HI, sa0_s2_reg});  // [R21] [R15]
  assign is_cont     = rx_byte_i[CONT_BIT];
  assign is_ptr_load = !rx_byte_i[6];                                     // [R6]
  assign is_mode_set = (rx_byte_i[6:5] == OPC_MODE_SET);                  // [R1]
  assign is_dev_sel  = (rx_byte_i[6:3] == OPC_DEV_SELECT);                // [R7]
  assign is_bank_sel = (rx_byte_i[6:2] == OPC_BANK_SELECT);               // [R8]
  assign is_blink    = (rx_byte_i[6:3] == OPC_BLINK);                     // [R11]
  assign mux_low     = (drive_mode_o == MODE_STATIC) || (drive_mode_o == MODE_MUX2);
  assign sub_match   = (subaddr_counter_o == sub_s2_reg);                 // [R15]
  assign cmd_byte    = rx_valid_i && !rx_start_i && !rx_stop_i && (state_reg == XF_CMD);
  assign data_byte   = rx_valid_i && !rx_start_i && !rx_stop_i && (state_reg == XF_DATA);

  // Transfer sequencing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= XF_IDLE;
    end else if (rx_start_i) begin
      state_reg <= XF_ADDR;
    end else if (rx_stop_i) begin
      state_reg <= XF_IDLE;
    end else if (rx_valid_i) begin
      unique case (state_reg)
        XF_ADDR: state_reg <= addr_match ? XF_CMD : XF_SKIP;              // [R21]
        XF_CMD:  state_reg <= is_cont ? XF_CMD : XF_DATA;                 // [R20]
        XF_DATA: state_reg <= XF_DATA;
        XF_SKIP: state_reg <= XF_SKIP;
        XF_IDLE: state_reg <= XF_IDLE;
      endcase
    end
  end

  // Acknowledge decision, one pulse per address byte and per byte of a selected transfer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_valid_o <= 1'b0;
      ack_o       <= 1'b0;
    end else begin
      ack_valid_o <= rx_valid_i && !rx_start_i && !rx_stop_i &&
                     (state_reg != XF_IDLE) && (state_reg != XF_SKIP);
      if (rx_valid_i) begin
        unique case (state_reg)
          XF_ADDR: ack_o <= addr_match;
          XF_CMD:  ack_o <= 1'b1;                                         // [R23]
          XF_DATA: ack_o <= sub_match;                                    // [R22]
          XF_SKIP: ack_o <= 1'b0;
          XF_IDLE: ack_o <= 1'b0;
        endcase
      end
    end
  end

  // Mode set command
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_mode_o     <= RST_DRIVE_MODE;
      bias_half_o      <= RST_BIAS;
      display_en_o     <= RST_DISPLAY_EN;
      power_save_bit_o <= RST_POWER_SAVE;
    end else if (cmd_byte && is_mode_set) begin                           // [R14]
      drive_mode_o     <= rx_byte_i[1:0];                                 // [R2]
      bias_half_o      <= rx_byte_i[POS_BIAS];                            // [R3]
      display_en_o     <= rx_byte_i[POS_DISPLAY_EN];                      // [R4]
      power_save_bit_o <= rx_byte_i[POS_POWER_SAVE];                      // [R5]
    end
  end

  // Drive mode hand-over to the display clock: toggle on each mode set
  logic mode_tgl_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_tgl_reg <= 1'b0;
    end else if (cmd_byte && is_mode_set) begin
      mode_tgl_reg <= !mode_tgl_reg;
    end
  end

  // Bank and blink settings
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_in_o  <= 1'b0;
      bank_out_o <= 1'b0;
    end else if (cmd_byte && is_bank_sel && mux_low) begin                // [R10]
      bank_in_o  <= rx_byte_i[POS_BANK_IN];                               // [R8]
      bank_out_o <= rx_byte_i[POS_BANK_OUT];                              // [R9]
    end
  end

  logic blink_alt_req_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blink_rate_o      <= RST_BLINK_RATE;
      blink_alt_req_reg <= 1'b0;
    end else if (cmd_byte && is_blink) begin
      blink_rate_o      <= rx_byte_i[1:0];                                // [R12]
      blink_alt_req_reg <= rx_byte_i[POS_BLINK_ALT];                      // [R13]
    end
  end

  // Alternation blinking only applies in static and 1:2 modes; follows the command edge, never lags it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blink_alt_o <= 1'b0;
    end else if (cmd_byte && is_mode_set) begin
      blink_alt_o <= blink_alt_req_reg && (rx_byte_i[1:0] == MODE_STATIC || rx_byte_i[1:0] == MODE_MUX2); // [R13]
    end else if (cmd_byte && is_blink) begin
      blink_alt_o <= rx_byte_i[POS_BLINK_ALT] && mux_low;                 // [R13]
    end
  end

  // Pointer and subaddress: loaded by commands, advanced by data bytes
  logic [5:0] fill_step;
  logic [6:0] ptr_sum;

  always_comb begin
    unique case (drive_mode_o)
      MODE_STATIC: fill_step = FILL_STEP_STATIC;
      MODE_MUX2:   fill_step = FILL_STEP_MUX2;
      MODE_MUX3:   fill_step = FILL_STEP_MUX3;
      MODE_MUX4:   fill_step = FILL_STEP_MUX4;
    endcase
  end

  assign ptr_sum = {1'b0, ram_pointer_field_o} + {1'b0, fill_step};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ram_pointer_field_o <= RST_RAM_POINTER;
      subaddr_counter_o   <= RST_SUBADDR;
    end else if (cmd_byte && is_ptr_load) begin
      ram_pointer_field_o <= rx_byte_i[5:0];                              // [R6]
    end else if (cmd_byte && is_dev_sel) begin
      subaddr_counter_o   <= rx_byte_i[2:0];                              // [R7]
    end else if (data_byte) begin
      if (ptr_sum > RAM_ADDR_LAST) begin                                  // [R22]
        ram_pointer_field_o <= RST_RAM_POINTER;
        subaddr_counter_o   <= subaddr_counter_o + 3'h1;
      end else begin
        ram_pointer_field_o <= ptr_sum[5:0];
      end
    end
  end

  // Display RAM write, only when this device's subaddress is addressed
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ram_wr_o      <= 1'b0;
      ram_wr_addr_o <= 6'h00;
      ram_wr_bank_o <= 1'b0;
      ram_wr_data_o <= 8'h00;
    end else begin
      ram_wr_o <= data_byte && sub_match;                                 // [R22] [R14]
      if (data_byte) begin
        ram_wr_addr_o <= ram_pointer_field_o;
        ram_wr_bank_o <= bank_in_o && mux_low;                            // [R8]
        ram_wr_data_o <= rx_byte_i;
      end
    end
  end

  // Spare three-bit status field held low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unused_dummy_o <= '0;
    end else begin
      unused_dummy_o <= '0;
    end
  end

  // ---------------- Display clock domain ----------------
  logic       tgl_s1_reg;
  logic       tgl_s2_reg;
  logic       tgl_s3_reg;
  logic [1:0] link_mode_reg;
  logic       sync_s1_reg;
  logic       sync_s2_reg;
  logic       sync_s3_reg;

  always_ff @(posedge disp_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_s1_reg    <= 1'b0;
      tgl_s2_reg    <= 1'b0;
      tgl_s3_reg    <= 1'b0;
      link_mode_reg <= RST_DRIVE_MODE;
    end else begin
      tgl_s1_reg <= mode_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
      // Mode word is stable for many bus bits after its toggle flips
      if (tgl_s2_reg != tgl_s3_reg) begin
        link_mode_reg <= drive_mode_o;
      end
    end
  end

  always_ff @(posedge disp_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_s1_reg <= 1'b1;
      sync_s2_reg <= 1'b1;
      sync_s3_reg <= 1'b1;
    end else begin
      sync_s1_reg <= sync_n_i;
      sync_s2_reg <= sync_s1_reg;
      sync_s3_reg <= sync_s2_reg;
    end
  end

  // Backplane phase sequencer
  logic [3:0] tick_reg;
  logic [1:0] phase_reg;
  logic [1:0] last_phase;
  logic [1:0] phase_next;
  logic [3:0] tick_next;
  logic       sync_fall;

  always_comb begin
    unique case (link_mode_reg)
      MODE_STATIC: last_phase = 2'h0;
      MODE_MUX2:   last_phase = 2'h1;
      MODE_MUX3:   last_phase = 2'h2;
      MODE_MUX4:   last_phase = 2'h3;
    endcase
  end

  // Falling edge seen only while this device is not driving the line
  assign sync_fall = !sync_s2_reg && sync_s3_reg && !sync_oe_o;           // [R17]

  always_comb begin
    tick_next  = tick_reg + 4'h1;
    phase_next = phase_reg;
    if (sync_fall) begin
      tick_next  = 4'h0;                                                  // [R18]
      phase_next = last_phase;
    end else if (tick_reg >= BP_PHASE_CYCLES - 4'h1) begin
      tick_next  = 4'h0;
      phase_next = (phase_reg >= last_phase) ? 2'h0 : phase_reg + 2'h1;
    end
  end

  always_ff @(posedge disp_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_reg  <= 4'h0;                                                  // [R19]
      phase_reg <= 2'h0;
    end else begin
      tick_reg  <= tick_next;
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge disp_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_n_o           <= 1'b0;                                         // [R16]
      sync_oe_o          <= 1'b0;
      backplane_output_o <= 4'h1;
    end else begin
      sync_n_o           <= 1'b0;
      sync_oe_o          <= (phase_next == last_phase);                   // [R17] [R16]
      backplane_output_o <= 4'h1 << phase_next;
    end
  end

endmodule

`default_nettype wire

// file: bench/lcd_cmd_props.sv
// Port checks for the LCD command decoder
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_props
  import lcd_cmd_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       rx_valid_i,
  input wire logic       ack_valid_o,
  input wire logic       ack_o,
  input wire logic [1:0] drive_mode_o,
  input wire logic       bias_half_o,
  input wire logic       display_en_o,
  input wire logic       power_save_bit_o,
  input wire logic [5:0] ram_pointer_field_o,
  input wire logic [2:0] subaddr_counter_o,
  input wire logic       bank_in_o,
  input wire logic       bank_out_o,
  input wire logic [1:0] blink_rate_o,
  input wire logic       blink_alt_o,
  input wire logic       ram_wr_o,
  input wire logic [5:0] ram_wr_addr_o,
  input wire logic       ram_wr_bank_o,
  input wire logic       disp_clk_i,
  input wire logic       sync_n_o,
  input wire logic       sync_oe_o,
  input wire logic [3:0] backplane_output_o
);
  logic       bankable;
  logic [1:0] last_ph;
  logic [1:0] mode_seen;
  logic [3:0] mode_age;
  assign bankable = drive_mode_o == MODE_STATIC || drive_mode_o == MODE_MUX2;
  assign last_ph = drive_mode_o == MODE_STATIC ? 2'h0 : drive_mode_o == MODE_MUX2 ? 2'h1 :
                   drive_mode_o == MODE_MUX3 ? 2'h2 : 2'h3;
  // Mode needs a few link cycles to cross, so the last-phase sync check waits until it has settled
  always_ff @(posedge disp_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_seen <= RST_DRIVE_MODE;
      mode_age  <= 4'h0;
    end else begin
      mode_seen <= drive_mode_o;
      if (drive_mode_o != mode_seen) begin
        mode_age <= 4'h0;
      end else if (mode_age != 4'hf) begin
        mode_age <= mode_age + 4'h1;
      end
    end
  end
  a_ack_has_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ack_valid_o |-> $past(rx_valid_i)) else $error("answer without a received byte");
  a_status_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed({drive_mode_o, bias_half_o, display_en_o, power_save_bit_o, ram_pointer_field_o,
              subaddr_counter_o, blink_rate_o, blink_alt_o}) |-> ack_valid_o)
    else $error("status moved without an accepted byte");
  a_write_acked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ram_wr_o |-> ack_valid_o && ack_o && ram_wr_addr_o == $past(ram_pointer_field_o))
    else $error("ram write not tied to an acked byte at the pointer");
  a_write_bank: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ram_wr_o |-> ram_wr_bank_o == (bank_in_o && bankable)) else $error("wrong input bank on write");
  a_bank_frozen: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !bankable && $stable(drive_mode_o) |=> $stable({bank_in_o, bank_out_o}))
    else $error("bank changed in 1:3 or 1:4 mode");
  a_alt_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    blink_alt_o |-> bankable) else $error("alternation active in 1:3 or 1:4 mode");
  a_sync_drain: assert property (@(posedge disp_clk_i) disable iff (!rst_n_i)
    !sync_n_o) else $error("sync line driven high");
  a_phase_onehot: assert property (@(posedge disp_clk_i) disable iff (!rst_n_i)
    $onehot(backplane_output_o)) else $error("backplane phase not one-hot");
  a_sync_last_phase: assert property (@(posedge disp_clk_i) disable iff (!rst_n_i)
    mode_age == 4'hf |-> sync_oe_o == backplane_output_o[last_ph])
    else $error("sync drive not matching last phase");
  c_data_write: cover property (@(posedge clk_i) ram_wr_o);
  c_data_refused: cover property (@(posedge clk_i) ack_valid_o && !ack_o);
  c_sync_drive: cover property (@(posedge disp_clk_i) $rose(sync_oe_o));
endmodule
bind lcd_driver_command_decoder lcd_cmd_props i_lcd_cmd_props (
  .clk_i, .rst_n_i, .rx_valid_i, .ack_valid_o, .ack_o, .drive_mode_o, .bias_half_o, .display_en_o,
  .power_save_bit_o, .ram_pointer_field_o, .subaddr_counter_o, .bank_in_o, .bank_out_o, .blink_rate_o,
  .blink_alt_o, .ram_wr_o, .ram_wr_addr_o, .ram_wr_bank_o, .disp_clk_i, .sync_n_o, .sync_oe_o,
  .backplane_output_o
);
`default_nettype wire

// file: bench/lcd_bus_master_model.sv
// Bus master stand-in driving the receiver byte stream
`timescale 1ns/1ps
`default_nettype none
module lcd_bus_master_model (
  input  wire logic       clk_i,
  input  wire logic       ack_valid_i,
  input  wire logic       ack_i,
  output var  logic       rx_start_o,
  output var  logic       rx_stop_o,
  output var  logic       rx_valid_o,
  output var  logic [7:0] rx_byte_o
);
  initial begin
    rx_start_o = 1'b0;
    rx_stop_o  = 1'b0;
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'h5a;
  end
  // Start opens a frame, stop closes it; bytes only go in between
  task automatic frame_edge(input logic stop);
    @(posedge clk_i);
    #1;
    rx_start_o = !stop;
    rx_stop_o  = stop;
    @(posedge clk_i);
    #1;
    rx_start_o = 1'b0;
    rx_stop_o  = 1'b0;
  endtask
  // The answer lands one cycle after the byte; an idle byte lane shows the inverse
  task automatic put_byte(input logic [7:0] b, output logic got, output logic ack);
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b1;
    rx_byte_o  = b;
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b0;
    rx_byte_o  = ~b;
    got = ack_valid_i;
    ack = ack_i;
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the LCD command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lcd_cmd_pkg::*;
  logic       clk_i, rst_n_i, disp_clk_i, ext_pull, slave_addr_low_pin_i, rx_start_i, rx_stop_i, rx_valid_i;
  logic       ack_valid_o, ack_o, bias_half_o, display_en_o, power_save_bit_o, bank_in_o, bank_out_o;
  logic       blink_alt_o, ram_wr_o, ram_wr_bank_o, sync_n_o, sync_oe_o;
  logic [7:0] rx_byte_i, ram_wr_data_o;
  logic [2:0] hw_subaddr_i, subaddr_counter_o, unused_dummy_o;
  logic [1:0] drive_mode_o, blink_rate_o;
  logic [5:0] ram_pointer_field_o, ram_wr_addr_o;
  logic [3:0] backplane_output_o;
  logic       got_v[8], ack_v[8], wr_v[8];
  logic [7:0] wd_v[8];
  logic [5:0] wa_v[8];
  int         failures, n_compared, cycles;
  wire logic  sync_n_i;
  // Open-drain wire with pull-up, low while either party pulls
  assign sync_n_i = (sync_oe_o ? sync_n_o : 1'b1) & !ext_pull;
  lcd_driver_command_decoder i_lcd_driver_command_decoder (
    .clk_i, .rst_n_i, .rx_start_i, .rx_stop_i, .rx_valid_i, .rx_byte_i, .ack_valid_o, .ack_o,
    .slave_addr_low_pin_i, .hw_subaddr_i, .drive_mode_o, .bias_half_o, .display_en_o, .power_save_bit_o,
    .ram_pointer_field_o, .subaddr_counter_o, .bank_in_o, .bank_out_o, .blink_rate_o, .blink_alt_o,
    .ram_wr_o, .ram_wr_addr_o, .ram_wr_bank_o, .ram_wr_data_o, .disp_clk_i, .sync_n_i, .sync_n_o,
    .sync_oe_o, .unused_dummy_o, .backplane_output_o
  );
  lcd_bus_master_model i_lcd_bus_master_model (
    .clk_i(clk_i), .ack_valid_i(ack_valid_o), .ack_i(ack_o), .rx_start_o(rx_start_i),
    .rx_stop_o(rx_stop_i), .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i)
  );
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    disp_clk_i = 1'b0;
    #2;
    forever #15 disp_clk_i = ~disp_clk_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  // One framed transfer, first byte is the address; answers and writes kept per byte
  task automatic xfer(input int n, input logic [63:0] b);
    i_lcd_bus_master_model.frame_edge(1'b0);
    for (int k = 0; k < n; k++) begin
      i_lcd_bus_master_model.put_byte(b[63-8*k -: 8], got_v[k], ack_v[k]);
      wr_v[k] = ram_wr_o;
      wa_v[k] = ram_wr_addr_o;
      wd_v[k] = ram_wr_data_o;
    end
    i_lcd_bus_master_model.frame_edge(1'b1);
  endtask
  task automatic sc_reset;
    check(8'(backplane_output_o), 8'h01);
    check(8'(unused_dummy_o), 8'h00);
    check(8'({drive_mode_o, blink_rate_o}), 8'({RST_DRIVE_MODE, RST_BLINK_RATE}));
  endtask
  task automatic sc_mode;
    for (int i = 0; i < 4; i++) begin
      xfer(2, {8'h70, 3'b010, i[0], i[1], !i[0], 2'(i), 48'h0});
      check(8'(got_v[1] & ack_v[1]), 8'h01);
      check(8'(drive_mode_o), 8'(i));
      check(8'(bias_half_o), 8'(!i[0]));
      check(8'({display_en_o, power_save_bit_o}), 8'({i[1], i[0]}));
    end
  endtask
  task automatic sc_data;
    xfer(6, {8'h70, 8'hc9, 8'he5, 8'h20, 8'ha5, 8'h3c, 16'h0});
    check(8'({ack_v[1], ack_v[2], ack_v[3]}), 8'h07);
    check(8'({got_v[4], ack_v[4], wr_v[4]}), 8'h07);
    check(8'(wa_v[4]), 8'h20);
    check(wd_v[4], 8'ha5);
    check(8'({got_v[5], ack_v[5], wr_v[5]}), 8'h04);
    check(8'(subaddr_counter_o), 8'h06);
    check(8'(ram_pointer_field_o), 8'h08);
  endtask
  task automatic sc_bank;
    xfer(4, {8'h70, 8'he5, 8'h7a, 8'h55, 32'h0});
    check(8'({bank_in_o, bank_out_o, wr_v[3]}), 8'h05);
    xfer(3, {8'h70, 8'hcb, 8'h79, 40'h0});
    check(8'({drive_mode_o, bank_in_o, bank_out_o}), 8'h0e);
  endtask
  task automatic sc_blink;
    for (int i = 0; i < 4; i++) begin
      xfer(3, {8'h70, 6'b110010, (i < 2) ? MODE_MUX2 : MODE_MUX4, 5'b01110, !i[0], 2'(i), 40'h0});
      check(8'({ack_v[2], blink_rate_o}), 8'({1'b1, 2'(i)}));
      check(8'(blink_alt_o), 8'(i < 2 && !i[0]));
    end
  endtask
  task automatic sc_refuse;
    xfer(2, {8'h72, 8'h49, 48'h0});
    check(8'({got_v[0], ack_v[0], got_v[1], drive_mode_o}), 8'h10);
    slave_addr_low_pin_i = 1'b1;
    repeat (4) @(posedge clk_i);
    xfer(3, {8'h72, 8'hc9, 8'h68, 40'h0});
    check(8'({got_v[2], ack_v[2], drive_mode_o}), 8'h0d);
  endtask
  task automatic sc_sync;
    xfer(2, {8'h72, 8'h48, 48'h0});
    repeat (20) @(posedge disp_clk_i);
    for (int k = 0; k < 40 && backplane_output_o !== 4'h8; k++) begin
      @(posedge disp_clk_i);
      #1;
    end
    for (int k = 0; k < 40 && backplane_output_o !== 4'h1; k++) begin
      @(posedge disp_clk_i);
      #1;
    end
    // Let the synchronised line settle high after our own pulse, so the pull is a fresh fall
    repeat (2) @(posedge disp_clk_i);
    #1;
    ext_pull = 1'b1;
    repeat (2) @(posedge disp_clk_i);
    #1;
    ext_pull = 1'b0;
    repeat (3) @(posedge disp_clk_i);
    #1;
    check(8'(backplane_output_o), 8'h08);
    check(8'(sync_oe_o), 8'h01);
  endtask
  initial begin
    rst_n_i = 1'b0;
    ext_pull = 1'b0;
    slave_addr_low_pin_i = 1'b0;
    hw_subaddr_i = 3'h5;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    repeat (5) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    sc_reset();
    repeat (3) @(posedge clk_i);
    sc_mode();
    sc_data();
    sc_bank();
    sc_blink();
    sc_refuse();
    sc_sync();
    complete_run();
  end
endmodule
`default_nettype wire
